// ===== dcd_pkg.sv
// Constants, field layouts and helpers shared by both ends of the descriptor chain DMA
//
// Behaviour
// R1: Processor writes descriptor chain before requesting execution
// R2: Descriptor holds size, source, destination, next pointer
// R3: Descriptors fetched by dedicated RAM memory master
// R4: Completion flag written back into finished descriptor
// R5: Follow next pointer after descriptor completes
// R6: Run chain unattended until its end, then stop
// R7: Register bank holds addresses and byte count
// R8: Processor touches register bank once per transfer
// R9: Processor reloads register bank before each transfer
// R10: Processor waits while DMA owns the bus
// R11: Master reaches any peripheral bus slave address
// R12: Peripheral bus logic runs at half clock
// R13: No I/O buffers: memory and peripheral only
// R14: Zero next pointer ends chain; single done bit
package dcd_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DCD_AW = 8;                 // Descriptor RAM word address width
  localparam int DCD_DW = 32;                // Data and address width
  localparam int DCD_CW = 16;                // Word counter width
  localparam int FIFO_DEPTH = 8;             // Staging FIFO depth in words

  // ****************************************************************
  // Descriptor layout, word offsets from the descriptor base
  // ****************************************************************
  localparam logic [1:0] DESC_CTRL = 2'h0;   // Byte count in low bits, done flag on top
  localparam logic [1:0] DESC_SRC  = 2'h1;
  localparam logic [1:0] DESC_DST  = 2'h2;
  localparam logic [1:0] DESC_NEXT = 2'h3;
  localparam logic [2:0] DESC_WORDS = 3'h4;
  localparam logic [DCD_DW-1:0] CTRL_DONE_MASK = 32'h8000_0000;
  localparam logic [DCD_AW-1:0] CHAIN_END = 8'h00;

  // ****************************************************************
  // Register bank selects, modes, user command kinds, resets
  // ****************************************************************
  localparam logic [1:0] CFG_SRC  = 2'h0;
  localparam logic [1:0] CFG_DST  = 2'h1;
  localparam logic [1:0] CFG_CNT  = 2'h2;
  localparam logic [1:0] CFG_HEAD = 2'h3;
  localparam logic MODE_REG  = 1'b0;
  localparam logic MODE_DESC = 1'b1;
  localparam logic [1:0] KIND_RAMWR = 2'h0;
  localparam logic [1:0] KIND_RAMRD = 2'h1;
  localparam logic [1:0] KIND_CFG   = 2'h2;
  localparam logic [1:0] KIND_START = 2'h3;
  localparam logic [DCD_DW-1:0] CFG_RESET = 32'h0;

  // ****************************************************************
  // Peripheral bus
  // ****************************************************************
  localparam int PB_DIV = 2;                 // Bus clock divider, realised as a toggle
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [DCD_DW-1:0] ADDR_STEP = 32'h4;

  // Bytes to words, rounding a partial last word up
  function automatic logic [DCD_CW-1:0] dcdWords(input logic [DCD_DW-1:0] b);
    return b[DCD_CW+1:2] + {{(DCD_CW-1){1'b0}}, |b[1:0]};
  endfunction

endpackage

// ===== dcd_link_if.sv
// Interface joining the processor end and the DMA end
`timescale 1ns/1ns
interface dcd_link_if;
  import dcd_pkg::*;

  // Processor side port of the descriptor RAM
  logic              ramWe;
  logic [DCD_AW-1:0] ramAddr;
  logic [DCD_DW-1:0] ramWdata;
  logic [DCD_DW-1:0] ramRdata;
  // Register bank writes and start
  logic              cfgWe;
  logic [1:0]        cfgSel;
  logic [DCD_DW-1:0] cfgData;
  logic              start;
  logic              startMode;
  // Status back to the processor
  logic              busy;
  logic              doneEvt;

  modport dma (
    input  ramWe, ramAddr, ramWdata, cfgWe, cfgSel, cfgData, start, startMode,
    output ramRdata, busy, doneEvt
  );
  modport cpu (
    output ramWe, ramAddr, ramWdata, cfgWe, cfgSel, cfgData, start, startMode,
    input  ramRdata, busy, doneEvt
  );
endinterface

// ===== dcd_fifo.sv
// Word FIFO staging data between the read and write halves of a transfer
`timescale 1ns/1ns
module dcd_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  // Clock, reset and enable
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Filling side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Draining side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  import dcd_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } dcd_fifo_state_t;

  dcd_fifo_state_t s;
  dcd_fifo_state_t n;
  logic [W-1:0]    mem [DEPTH];
  logic            push;
  logic            pop;

  // Wrapping increment, so depths that are not a power of two still work
  function automatic logic [PW-1:0] dcdInc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Handshakes and flags straight from the occupancy count
  assign inReady  = (s.cnt != (PW+1)'(DEPTH));
  assign outValid = (s.cnt != '0);
  assign outData  = mem[s.rp];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer and count update
  always_comb begin
    n = s;
    if (push) begin
      n.wp = dcdInc(s.wp);
    end
    if (pop) begin
      n.rp = dcdInc(s.rp);
    end
    n.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  // Storage, not reset
  always_ff @(posedge clk_sys) begin
    if (ce && push) begin
      mem[s.wp] <= inData;
    end
  end

endmodule

// ===== dcd_dma.sv
// DMA end: register bank, descriptor RAM with its memory master, bus master
`timescale 1ns/1ns
module dcd_dma #(
  parameter int FIFO_DEPTH = dcd_pkg::FIFO_DEPTH
) (
  // Clock, reset and enable
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // Link to the processor end
  dcd_link_if.dma                        lnk,
  // Peripheral bus master
  output logic                           pbClk,
  output logic [dcd_pkg::DCD_DW-1:0]     HADDR,
  output logic [1:0]                     HTRANS,
  output logic                           HWRITE,
  output logic [dcd_pkg::DCD_DW-1:0]     HWDATA,
  input  wire logic [dcd_pkg::DCD_DW-1:0] HRDATA,
  input  wire logic                      HREADY
);
  import dcd_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_XFER, ST_RD_ADDR, ST_RD_DATA,
    ST_WR_ADDR, ST_WR_DATA, ST_FLAG, ST_NEXT
  } dcd_state_t;

  typedef struct packed {
    dcd_state_t        st;
    logic              hclk;
    logic              descMode;
    logic [DCD_AW-1:0] desc;
    logic [2:0]        fIdx;
    logic [DCD_DW-1:0] ctrl;
    logic [DCD_DW-1:0] src;
    logic [DCD_DW-1:0] dst;
    logic [DCD_AW-1:0] next;
    logic [DCD_CW-1:0] rdLeft;
    logic [DCD_CW-1:0] wrLeft;
    logic [DCD_DW-1:0] regSrc;
    logic [DCD_DW-1:0] regDst;
    logic [DCD_DW-1:0] regCnt;
    logic [DCD_AW-1:0] regHead;
    logic              busy;
    logic              doneEvt;
    logic [DCD_DW-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [DCD_DW-1:0] hwdata;
  } dcd_dma_state_t;

  dcd_dma_state_t    s;
  dcd_dma_state_t    n;
  logic [DCD_DW-1:0] mem [2**DCD_AW];
  logic [DCD_DW-1:0] ramA;
  logic [DCD_DW-1:0] ramB;
  logic [DCD_AW-1:0] mmAddr;
  logic [DCD_DW-1:0] mmWdata;
  logic              mmWe;
  logic              pbEdge;
  logic [1:0]        capIdx;
  logic              fifoInValid;
  logic              fifoInReady;
  logic              fifoOutValid;
  logic              fifoOutReady;
  logic [DCD_DW-1:0] fifoOutData;

  // ****************************************************************
  // Descriptor RAM and its memory master port
  // ****************************************************************

  // Memory master addresses the descriptor word being fetched or flagged
  assign mmAddr  = (s.st == ST_FLAG) ? s.desc + DCD_AW'(DESC_CTRL)
                                     : s.desc + DCD_AW'(s.fIdx);            // [R3]
  assign mmWe    = (s.st == ST_FLAG);                                       // [R4]
  assign mmWdata = s.ctrl | CTRL_DONE_MASK;                                 // [R14]
  assign capIdx  = 2'(s.fIdx - 3'h1);

  // True dual port: the flag write is ordered last so it wins a same-word collision
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (lnk.ramWe) begin
        mem[lnk.ramAddr] <= lnk.ramWdata;
      end
      if (mmWe) begin
        mem[mmAddr] <= mmWdata;
      end
      ramA <= mem[lnk.ramAddr];
      ramB <= mem[mmAddr];
    end
  end

  // ****************************************************************
  // Staging FIFO between read and write phases
  // ****************************************************************

  // Only memory and peripheral endpoints: no receive or transmit buffers
  assign fifoInValid  = (s.st == ST_RD_DATA) && pbEdge && HREADY;           // [R13]
  assign fifoOutReady = (s.st == ST_WR_DATA) && pbEdge && HREADY;

  dcd_fifo #(
    .W     (DCD_DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (HRDATA),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // ****************************************************************
  // Control
  // ****************************************************************

  // Bus logic only moves on the cycle that raises the half-rate bus clock
  assign pbEdge = ~s.hclk;                                                  // [R12]

  // Next state
  always_comb begin
    n         = s;
    n.doneEvt = 1'b0;
    n.hclk    = ~s.hclk;                                                    // [R12]
    // Bank writes are dropped while a transfer owns the bus
    if (lnk.cfgWe && !s.busy) begin                                         // [R7]
      case (lnk.cfgSel)
        CFG_SRC: n.regSrc = lnk.cfgData;
        CFG_DST: n.regDst = lnk.cfgData;
        CFG_CNT: n.regCnt = lnk.cfgData;
        default: n.regHead = lnk.cfgData[DCD_AW-1:0];
      endcase
    end
    case (s.st)
      ST_IDLE: begin
        if (lnk.start) begin
          n.busy     = 1'b1;
          n.descMode = lnk.startMode;
          if (lnk.startMode == MODE_REG) begin
            n.src    = s.regSrc;                                            // [R7]
            n.dst    = s.regDst;
            n.rdLeft = dcdWords(s.regCnt);
            n.wrLeft = dcdWords(s.regCnt);
            n.st     = ST_XFER;
          end else if (s.regHead == CHAIN_END) begin
            // Empty chain finishes at once
            n.busy    = 1'b0;                                               // [R14]
            n.doneEvt = 1'b1;
          end else begin
            n.desc = s.regHead;
            n.fIdx = 3'h0;
            n.st   = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        // RAM answers one cycle after the address, so capture lags the index
        if (s.fIdx != 3'h0) begin
          case (capIdx)                                                     // [R2]
            DESC_CTRL: n.ctrl = ramB;
            DESC_SRC:  n.src  = ramB;
            DESC_DST:  n.dst  = ramB;
            default:   n.next = ramB[DCD_AW-1:0];
          endcase
        end
        n.fIdx = s.fIdx + 3'h1;
        if (s.fIdx == DESC_WORDS) begin
          n.rdLeft = dcdWords({{(DCD_DW-DCD_CW){1'b0}}, s.ctrl[DCD_CW-1:0]});
          n.wrLeft = dcdWords({{(DCD_DW-DCD_CW){1'b0}}, s.ctrl[DCD_CW-1:0]});
          n.st     = ST_XFER;
        end
      end
      ST_XFER: begin
        // Reads go first whenever the FIFO has room; writes go only when it is full or all reads are done
        if (pbEdge) begin
          if (s.rdLeft != '0 && fifoInReady) begin
            n.haddr  = s.src;                                               // [R11]
            n.htrans = HTRANS_NONSEQ;
            n.hwrite = 1'b0;
            n.st     = ST_RD_ADDR;
          end else if (fifoOutValid) begin
            n.haddr  = s.dst;                                               // [R11]
            n.htrans = HTRANS_NONSEQ;
            n.hwrite = 1'b1;
            n.st     = ST_WR_ADDR;
          end else if (s.wrLeft == '0) begin
            n.st = s.descMode ? ST_FLAG : ST_NEXT;
          end
        end
      end
      ST_RD_ADDR: begin
        if (pbEdge) begin
          n.htrans = HTRANS_IDLE;
          n.st     = ST_RD_DATA;
        end
      end
      ST_RD_DATA: begin
        if (pbEdge && HREADY) begin
          n.src    = s.src + ADDR_STEP;
          n.rdLeft = s.rdLeft - DCD_CW'(1);
          n.st     = ST_XFER;
        end
      end
      ST_WR_ADDR: begin
        if (pbEdge) begin
          n.htrans = HTRANS_IDLE;
          n.hwdata = fifoOutData;
          n.st     = ST_WR_DATA;
        end
      end
      ST_WR_DATA: begin
        if (pbEdge && HREADY) begin
          n.dst    = s.dst + ADDR_STEP;
          n.wrLeft = s.wrLeft - DCD_CW'(1);
          n.st     = ST_XFER;
        end
      end
      ST_FLAG: begin
        n.st = ST_NEXT;                                                     // [R4]
      end
      ST_NEXT: begin
        // Chain walks on with no processor help until a zero pointer
        if (s.descMode && s.next != CHAIN_END) begin                        // [R14]
          n.desc = s.next;                                                  // [R5]
          n.fIdx = 3'h0;
          n.st   = ST_FETCH;                                                // [R6]
        end else begin
          n.busy    = 1'b0;                                                 // [R6]
          n.doneEvt = 1'b1;
          n.st      = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s      <= '0;
      s.st   <= ST_IDLE;
      s.regSrc <= CFG_RESET;
      s.regDst <= CFG_RESET;
      s.regCnt <= CFG_RESET;
      s.htrans <= HTRANS_IDLE;
    end else if (ce) begin
      s <= n;
    end
  end

  // Outputs straight from the state register, RAM read data from ramA
  assign pbClk       = s.hclk;
  assign HADDR       = s.haddr;
  assign HTRANS      = s.htrans;
  assign HWRITE      = s.hwrite;
  assign HWDATA      = s.hwdata;
  assign lnk.busy    = s.busy;
  assign lnk.doneEvt = s.doneEvt;
  assign lnk.ramRdata = ramA;

endmodule

// ===== dcd_cpu.sv
// Processor end: builds chains, loads the register bank and starts transfers
`timescale 1ns/1ns
module dcd_cpu (
  // Clock, reset and enable
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  // Link to the DMA end
  dcd_link_if.cpu                         lnk,
  // User command port
  input  wire logic                       usrValid,
  input  wire logic [1:0]                 usrKind,
  input  wire logic [dcd_pkg::DCD_AW-1:0] usrAddr,
  input  wire logic [dcd_pkg::DCD_DW-1:0] usrData,
  input  wire logic                       usrMode,
  output logic                            usrReady,
  // User answers
  output logic [dcd_pkg::DCD_DW-1:0]      usrRdata,
  output logic                            usrRvalid,
  output logic                            usrDone,
  output logic                            usrRefused
);
  import dcd_pkg::*;

  typedef struct packed {
    logic              ramWe;
    logic [DCD_AW-1:0] ramAddr;
    logic [DCD_DW-1:0] ramWdata;
    logic              cfgWe;
    logic [1:0]        cfgSel;
    logic [DCD_DW-1:0] cfgData;
    logic              start;
    logic              startMode;
    logic              running;
    logic              loaded;
    logic [1:0]        rdPend;
    logic [DCD_DW-1:0] rdata;
    logic              rvalid;
    logic              done;
    logic              refused;
    logic              ready;
  } dcd_cpu_state_t;

  dcd_cpu_state_t s;
  dcd_cpu_state_t n;

  // ****************************************************************
  // Command handling
  // ****************************************************************

  // Next state; strobes last one cycle
  always_comb begin
    n         = s;
    n.ramWe   = 1'b0;
    n.cfgWe   = 1'b0;
    n.start   = 1'b0;
    n.rvalid  = 1'b0;
    n.done    = 1'b0;
    n.refused = 1'b0;
    // RAM read data arrives two cycles after the take, one after the address goes out
    n.rdPend = {s.rdPend[0], 1'b0};
    if (s.rdPend[1]) begin
      n.rdata  = lnk.ramRdata;
      n.rvalid = 1'b1;
    end
    if (usrValid && s.ready) begin
      case (usrKind)
        KIND_RAMWR: begin
          n.ramWe    = 1'b1;                                                // [R1]
          n.ramAddr  = usrAddr;
          n.ramWdata = usrData;
        end
        KIND_RAMRD: begin
          n.ramAddr   = usrAddr;
          n.rdPend[0] = 1'b1;
        end
        KIND_CFG: begin
          n.cfgWe   = 1'b1;                                                 // [R8]
          n.cfgSel  = usrAddr[1:0];
          n.cfgData = usrData;
          n.loaded  = 1'b1;
        end
        default: begin
          // A register transfer needs a fresh bank load since the last start
          if (usrMode == MODE_REG && !s.loaded) begin
            n.refused = 1'b1;                                               // [R9]
          end else begin
            n.start     = 1'b1;
            n.startMode = usrMode;
            n.running   = 1'b1;
            n.loaded    = 1'b0;                                             // [R9]
          end
        end
      endcase
    end
    if (lnk.doneEvt) begin
      n.running = 1'b0;
      n.done    = 1'b1;
    end
    // Hold everything off while the DMA owns the bus
    n.ready = !n.running && !lnk.busy;                                      // [R10]
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign lnk.ramWe     = s.ramWe;
  assign lnk.ramAddr   = s.ramAddr;
  assign lnk.ramWdata  = s.ramWdata;
  assign lnk.cfgWe     = s.cfgWe;
  assign lnk.cfgSel    = s.cfgSel;
  assign lnk.cfgData   = s.cfgData;
  assign lnk.start     = s.start;
  assign lnk.startMode = s.startMode;
  assign usrReady      = s.ready;
  assign usrRdata      = s.rdata;
  assign usrRvalid     = s.rvalid;
  assign usrDone       = s.done;
  assign usrRefused    = s.refused;

endmodule

// ===== dcd_link_chk.sv
// Checker watching the link and bus signals between the two ends
`timescale 1ns/1ns
module dcd_link_chk
  import dcd_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_n,
  // Link signals
  input wire logic              start,
  input wire logic              startMode,
  input wire logic              cfgWe,
  input wire logic [1:0]        cfgSel,
  input wire logic [DCD_DW-1:0] cfgData,
  input wire logic              busy,
  input wire logic              doneEvt,
  // Bus side
  input wire logic              pbClk,
  input wire logic [1:0]        HTRANS
);
  logic [DCD_DW-1:0] headReg;
  logic              emptyGo;

  // Shadow of the chain head; writes during a run are dropped by the DMA
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      headReg <= CFG_RESET;
    end else if (cfgWe && !busy && cfgSel == CFG_HEAD) begin
      headReg <= cfgData;
    end
  end
  assign emptyGo = startMode == MODE_DESC && headReg[DCD_AW-1:0] == CHAIN_END;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  pbclk_toggle_a: assert property ($past(rst_n) |-> pbClk != $past(pbClk))
    else $error("bus clock did not toggle");
  addr_phase_a: assert property ($rose(HTRANS == HTRANS_NONSEQ) |=>
    HTRANS == HTRANS_NONSEQ ##1 HTRANS == HTRANS_IDLE) else $error("address phase length");
  empty_chain_a: assert property (start && !busy && emptyGo |=> doneEvt && !busy)
    else $error("empty chain did not finish at once");
  run_start_a: assert property (start && !busy && !emptyGo |=> busy && !doneEvt)
    else $error("start did not raise busy");
  busy_fall_a: assert property ($fell(busy) |-> doneEvt)
    else $error("busy fell without done");
  done_pulse_a: assert property (doneEvt |=> !doneEvt)
    else $error("done longer than one cycle");
  busy_cause_a: assert property ($rose(busy) |-> $past(start))
    else $error("busy rose without start");
  done_cause_a: assert property (doneEvt |-> $past(busy) || $past(start))
    else $error("done without a run");
endmodule

// ===== descriptor_chain_dma_test.sv
// Self-checking bench joining the processor end and the DMA end
`timescale 1ns/1ns
module descriptor_chain_dma_test;
  import dcd_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic              ce = 1'b1;
  logic              usrValid = 1'b0;
  logic [1:0]        usrKind = 2'h0;
  logic [DCD_AW-1:0] usrAddr = 8'h00;
  logic [DCD_DW-1:0] usrData = 32'h0;
  logic              usrMode = 1'b0;
  logic              usrReady, usrRvalid, usrDone, usrRefused, HWRITE, pbClk;
  logic [DCD_DW-1:0] usrRdata, HADDR, HWDATA, HRDATA;
  logic [DCD_DW-1:0] hAddrReg = 32'h0;
  logic [1:0]        HTRANS;
  logic              HREADY = 1'b1;
  logic              hPend = 1'b0;
  logic              hWr = 1'b0;
  logic              stall = 1'b0;
  logic [DCD_DW-1:0] mem [256];
  logic [DCD_DW-1:0] expMem [256];
  int                n_errors = 0;
  int                tests_run = 0;
  int                seed = 32'hd91c;
  int                n;

  dcd_link_if dcd_link_if_inst();
  dcd_cpu dcd_cpu_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .lnk(dcd_link_if_inst),
    .usrValid(usrValid), .usrKind(usrKind), .usrAddr(usrAddr), .usrData(usrData),
    .usrMode(usrMode), .usrReady(usrReady), .usrRdata(usrRdata), .usrRvalid(usrRvalid),
    .usrDone(usrDone), .usrRefused(usrRefused));
  dcd_dma #(.FIFO_DEPTH(8)) dcd_dma_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .lnk(dcd_link_if_inst), .pbClk(pbClk), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADY(HREADY));
  dcd_link_chk dcd_link_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .start(dcd_link_if_inst.start), .startMode(dcd_link_if_inst.startMode),
    .cfgWe(dcd_link_if_inst.cfgWe), .cfgSel(dcd_link_if_inst.cfgSel),
    .cfgData(dcd_link_if_inst.cfgData), .busy(dcd_link_if_inst.busy),
    .doneEvt(dcd_link_if_inst.doneEvt), .pbClk(pbClk), .HTRANS(HTRANS));

  always #5 clk_sys = ~clk_sys;
  // Slave wait states, random while stalling so the FIFO backs up
  always @(posedge clk_sys) #1 HREADY = !stall || ($random(seed) % 3 != 0);
  // Single-transfer bus slave, acting only on bus edges
  always @(posedge clk_sys) begin
    if (!pbClk) begin
      if (hPend && HREADY && hWr) mem[hAddrReg[9:2]] <= HWDATA;
      if (hPend && HREADY) hPend <= 1'b0;
      if (HTRANS == HTRANS_NONSEQ) begin
        hPend <= 1'b1;
        hAddrReg <= HADDR;
        hWr <= HWRITE;
      end
    end
  end
  // Outside a data phase the read bus shows garbage, not old data
  assign HRDATA = hPend ? mem[hAddrReg[9:2]] : ~mem[hAddrReg[9:2]];

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [DCD_DW-1:0] e, input logic [DCD_DW-1:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmd(input logic [1:0] k, input logic [DCD_AW-1:0] a, input logic [DCD_DW-1:0] d);
    int i;
    @(posedge clk_sys) #1;
    for (i = 0; i < 3000 && usrReady !== 1'b1; i++) @(posedge clk_sys) #1;
    if (i == 3000) begin
      n_errors++;
      report_and_stop();
    end
    usrValid = 1'b1;
    usrKind = k;
    usrAddr = a;
    usrData = d;
    @(posedge clk_sys) #1;
    usrValid = 1'b0;
  endtask
  task automatic ramRead(input logic [DCD_AW-1:0] a, input logic [DCD_DW-1:0] e);
    cmd(KIND_RAMRD, a, 32'h0);
    // Read answer stands for the one cycle after the second edge past the take
    repeat (2) @(posedge clk_sys);
    #1;
    check("rvalid", 32'h1, {31'h0, usrRvalid});
    check("rdata", e, usrRdata);
  endtask
  task automatic run(input logic m, input logic refuse);
    int i;
    usrMode = m;
    cmd(KIND_START, 8'h00, 32'h0);
    // Refusal pulse stands only in the cycle right after the take
    check("refused", {31'h0, refuse}, {31'h0, usrRefused});
    check("ready", {31'h0, refuse}, {31'h0, usrReady});
    for (i = 0; i < 5000 && !refuse && usrDone !== 1'b1; i++) @(posedge clk_sys) #1;
    if (i == 5000) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  // Bench model of one transfer; partial last word is moved whole
  task automatic xfer(input int s, input int d, input int b);
    for (int i = 0; i < (b + 3) / 4; i++) expMem[d / 4 + i] = expMem[s / 4 + i];
  endtask
  task automatic cmpMem(input string what);
    for (int i = 0; i < 256; i++) check("memory", expMem[i], mem[i]);
    $display("Test %s finished", what);
  endtask
  task automatic desc(input logic [7:0] at, input int b, input int s, input int d,
                      input logic [7:0] nx);
    cmd(KIND_RAMWR, at, 32'(b));
    cmd(KIND_RAMWR, at + 8'h1, 32'(s));
    cmd(KIND_RAMWR, at + 8'h2, 32'(d));
    cmd(KIND_RAMWR, at + 8'h3, {24'h0, nx});
  endtask

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = $random(seed);
      expMem[i] = mem[i];
    end
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    // Register bank run, 10 to 16 words so the FIFO fills under stalls
    stall = 1'b1;
    n = 40 + ($unsigned($random(seed)) % 24);
    cmd(KIND_CFG, {6'h0, CFG_SRC}, 32'h40);
    cmd(KIND_CFG, {6'h0, CFG_DST}, 32'h200);
    cmd(KIND_CFG, {6'h0, CFG_CNT}, 32'(n));
    run(MODE_REG, 1'b0);
    xfer(32'h40, 32'h200, n);
    cmpMem("register");
    // Second start without fresh setup must be turned away
    run(MODE_REG, 1'b1);
    cmpMem("refused");
    // Two-descriptor chain, second one with a ragged count
    desc(8'h10, 8, 32'h80, 32'h280, 8'h20);
    desc(8'h20, 13, 32'ha0, 32'h2c0, 8'h00);
    cmd(KIND_CFG, {6'h0, CFG_HEAD}, 32'h10);
    run(MODE_DESC, 1'b0);
    xfer(32'h80, 32'h280, 8);
    xfer(32'ha0, 32'h2c0, 13);
    cmpMem("chain");
    ramRead(8'h10, CTRL_DONE_MASK | 32'h8);
    ramRead(8'h20, CTRL_DONE_MASK | 32'hd);
    ramRead(8'h23, 32'h0);
    // Empty chain finishes with no bus traffic
    cmd(KIND_CFG, {6'h0, CFG_HEAD}, 32'h0);
    run(MODE_DESC, 1'b0);
    cmpMem("empty chain");
    report_and_stop();
  end
endmodule
